//--- verilog/acs_pkg.sv
package acs_pkg;

  // ==========================================================
  // result format
  localparam int RES_W = 14;
  localparam int CODE_STEPS = 16384;
  localparam logic [RES_W-1:0] CODE_ZERO = 14'h0000;
  localparam logic [RES_W-1:0] CODE_MINUS_ONE = 14'h3fff;
  localparam logic [RES_W-1:0] CODE_POS_FULL = 14'h1fff;
  localparam logic [RES_W-1:0] CODE_POS_NEAR = 14'h1ffe;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 950;
  localparam int CONV_MAX_NS = 1150;
  localparam int ACQ_TIME_NS = 300;
  localparam int THRU_TIME_NS = 1250;
  localparam int NAP_WAKE_NS = 400;
  localparam int SLEEP_WAKE_MS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYCLES = ACQ_TIME_NS / CLK_PERIOD_NS;
  localparam int THRU_CYCLES = THRU_TIME_NS / CLK_PERIOD_NS;
  localparam int NAP_WAKE_CYCLES = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_CYCLES =
    (SLEEP_WAKE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 21;
  localparam int STROBE_CYCLES = 2;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================
  // state machines
  typedef enum logic [4:0] {
    DEV_ACQ = 5'b00001,
    DEV_READY = 5'b00010,
    DEV_CONV = 5'b00100,
    DEV_DOWN = 5'b01000,
    DEV_WAKE = 5'b10000
  } acs_dev_state_e;

  typedef enum logic [6:0] {
    HST_IDLE = 7'b0000001,
    HST_TRIG = 7'b0000010,
    HST_WAIT = 7'b0000100,
    HST_READ = 7'b0001000,
    HST_GAP = 7'b0010000,
    HST_DOWN = 7'b0100000,
    HST_WAKE = 7'b1000000
  } acs_host_state_e;

  typedef struct packed {
    acs_dev_state_e st;
    logic [TMR_W-1:0] tmr;
    logic trig_d;
    logic sleep_sel;
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] result;
    logic busy_n;
    logic oe_n;
    logic ready;
    logic nap;
    logic sleep;
  } acs_dev_s;

  localparam acs_dev_s DEV_RST = '{st: DEV_ACQ, tmr: '0, trig_d: 1'b1, sleep_sel: 1'b0,
    held: CODE_ZERO, result: CODE_ZERO, busy_n: 1'b1, oe_n: 1'b1, ready: 1'b0,
    nap: 1'b0, sleep: 1'b0};

  typedef struct packed {
    acs_host_state_e st;
    logic [TMR_W-1:0] tmr;
    logic seen_busy;
    logic sleep_sel;
    logic trig_n;
    logic select_n;
    logic read_n;
    logic pd_n;
    logic [RES_W-1:0] result;
    logic result_valid;
    logic idle;
  } acs_host_s;

  localparam acs_host_s HOST_RST = '{st: HST_WAKE, tmr: '0, seen_busy: 1'b0,
    sleep_sel: 1'b0, trig_n: 1'b1, select_n: 1'b0, read_n: 1'b1, pd_n: 1'b1,
    result: CODE_ZERO, result_valid: 1'b0, idle: 1'b0};

endpackage

//--- verilog/acs_link_if.sv
`timescale 1ns/1ps
interface acs_link_if;
  import acs_pkg::*;
  logic conversion_trigger_n;
  logic select_n;
  logic read_n;
  logic power_down_n;
  logic busy_n;
  logic data_oe_n;
  logic [RES_W-1:0] data;

  modport dev (
    input conversion_trigger_n, select_n, read_n, power_down_n,
    output busy_n, data_oe_n, data
  );
  modport host (
    output conversion_trigger_n, select_n, read_n, power_down_n,
    input busy_n, data_oe_n, data
  );
endinterface

//--- verilog/acs_device.sv
`timescale 1ns/1ps

// ==========================================================
// sample buffer
module acs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic in_rdy;
    logic out_vld;
  } acs_fifo_s;

  acs_fifo_s s_r;
  acs_fifo_s s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid_i & s_r.in_rdy;
  assign pop = out_ready_i & s_r.out_vld;
  assign in_ready_o = s_r.in_rdy;
  assign out_valid_o = s_r.out_vld;
  assign out_data_o = mem[s_r.rp];

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : AW'(s_r.wp + 1'b1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : AW'(s_r.rp + 1'b1);
    end
    if (push && !pop) begin
      s_nxt.cnt = CW'(s_r.cnt + 1'b1);
    end else if (pop && !push) begin
      s_nxt.cnt = CW'(s_r.cnt - 1'b1);
    end
    s_nxt.in_rdy = (s_nxt.cnt != CW'(DEPTH));
    s_nxt.out_vld = (s_nxt.cnt != '0);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '{wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[s_r.wp] <= in_data_i;
    end
  end
endmodule

// ==========================================================
// converter control end
module acs_device #(
  parameter int FIFO_DEPTH = acs_pkg::FIFO_DEPTH,
  parameter int SLEEP_WAKE_CYC = acs_pkg::SLEEP_WAKE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // link to host
  acs_link_if.dev link,
  // sample codes standing in for the analog input
  input wire logic [acs_pkg::RES_W-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // status
  output logic ready_o,
  output logic nap_o,
  output logic sleep_o
);
  import acs_pkg::*;

  acs_dev_s s_r;
  acs_dev_s s_nxt;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_in_ready;
  logic [RES_W-1:0] fifo_data;
  logic trig_fall;
  logic [TMR_W-1:0] wake_last;

  // ==========================================================
  // sample buffer in front of the hold stage
  acs_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i(sample_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // ==========================================================
  // control
  assign trig_fall = s_r.trig_d & ~link.conversion_trigger_n;
  assign wake_last = s_r.sleep_sel ? TMR_W'(SLEEP_WAKE_CYC - 1) :
                                     TMR_W'(NAP_WAKE_CYCLES - 1);

  always_comb begin
    s_nxt = s_r;
    fifo_pop = 1'b0;
    s_nxt.trig_d = link.conversion_trigger_n;
    if (!link.power_down_n && s_r.st != DEV_DOWN) begin
      // shutdown wins over any activity, running conversion is dropped
      s_nxt.st = DEV_DOWN;
      s_nxt.sleep_sel = link.select_n;
      s_nxt.tmr = '0;
    end else begin
      unique case (s_r.st)
        DEV_ACQ: begin
          if (s_r.tmr == TMR_W'(ACQ_CYCLES - 1)) begin
            s_nxt.st = DEV_READY;
            s_nxt.tmr = '0;
          end else begin
            s_nxt.tmr = TMR_W'(s_r.tmr + 1'b1);
          end
        end
        DEV_READY: begin
          if (trig_fall && !link.select_n) begin
            s_nxt.st = DEV_CONV;
            s_nxt.tmr = '0;
            fifo_pop = fifo_valid;
            if (fifo_valid) begin
              s_nxt.held = fifo_data;
            end
          end
        end
        DEV_CONV: begin
          // triggers are not looked at here
          if (s_r.tmr == TMR_W'(CONV_CYCLES - 1)) begin
            s_nxt.st = DEV_ACQ;
            s_nxt.tmr = '0;
            s_nxt.result = s_r.held;
          end else begin
            s_nxt.tmr = TMR_W'(s_r.tmr + 1'b1);
          end
        end
        DEV_DOWN: begin
          if (link.power_down_n) begin
            s_nxt.st = DEV_WAKE;
            s_nxt.tmr = '0;
          end
        end
        DEV_WAKE: begin
          // no trigger accepted until the wake-up count runs out
          if (s_r.tmr == wake_last) begin
            s_nxt.st = DEV_READY;
            s_nxt.tmr = '0;
          end else begin
            s_nxt.tmr = TMR_W'(s_r.tmr + 1'b1);
          end
        end
      endcase
    end
    s_nxt.busy_n = (s_nxt.st != DEV_CONV);
    s_nxt.oe_n = link.select_n | link.read_n;
    s_nxt.ready = (s_nxt.st == DEV_READY);
    s_nxt.nap = (s_nxt.st == DEV_DOWN) && !s_nxt.sleep_sel;
    s_nxt.sleep = (s_nxt.st == DEV_DOWN) && s_nxt.sleep_sel;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= DEV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign link.busy_n = s_r.busy_n;
  assign link.data_oe_n = s_r.oe_n;
  assign link.data = s_r.result;
  assign sample_ready_o = fifo_in_ready;
  assign ready_o = s_r.ready;
  assign nap_o = s_r.nap;
  assign sleep_o = s_r.sleep;
endmodule

//--- verilog/acs_host.sv
`timescale 1ns/1ps
module acs_host #(
  parameter int SLEEP_WAKE_CYC = acs_pkg::SLEEP_WAKE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // link to converter
  acs_link_if.host link,
  // user requests
  input wire logic conv_req_i,
  input wire logic down_req_i,
  input wire logic sleep_mode_i,
  // user results
  output logic [acs_pkg::RES_W-1:0] result_o,
  output logic result_valid_o,
  output logic idle_o
);
  import acs_pkg::*;

  acs_host_s s_r;
  acs_host_s s_nxt;
  logic [TMR_W-1:0] wake_last;

  assign wake_last = s_r.sleep_sel ? TMR_W'(SLEEP_WAKE_CYC) : TMR_W'(NAP_WAKE_CYCLES);

  // ==========================================================
  // sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.result_valid = 1'b0;
    s_nxt.tmr = TMR_W'(s_r.tmr + 1'b1);
    unique case (s_r.st)
      HST_IDLE: begin
        s_nxt.tmr = '0;
        if (down_req_i) begin
          s_nxt.st = HST_DOWN;
          s_nxt.sleep_sel = sleep_mode_i;
          s_nxt.select_n = sleep_mode_i;
        end else if (conv_req_i) begin
          s_nxt.st = HST_TRIG;
          s_nxt.select_n = 1'b0;
          s_nxt.trig_n = 1'b0;
        end
      end
      HST_TRIG: begin
        if (s_r.tmr == TMR_W'(STROBE_CYCLES - 1)) begin
          s_nxt.st = HST_WAIT;
          s_nxt.trig_n = 1'b1;
          s_nxt.seen_busy = 1'b0;
          s_nxt.tmr = '0;
        end
      end
      HST_WAIT: begin
        // bus stays quiet while the converter is busy
        if (!link.busy_n) begin
          s_nxt.seen_busy = 1'b1;
        end
        if (s_r.seen_busy && link.busy_n) begin
          s_nxt.st = HST_READ;
          s_nxt.read_n = 1'b0;
          s_nxt.tmr = '0;
        end else if (s_r.tmr == TMR_W'(THRU_CYCLES)) begin
          s_nxt.st = HST_GAP;
          s_nxt.tmr = '0;
        end
      end
      HST_READ: begin
        if (s_r.tmr == TMR_W'(STROBE_CYCLES - 1)) begin
          s_nxt.st = HST_GAP;
          s_nxt.read_n = 1'b1;
          s_nxt.result = link.data;
          s_nxt.result_valid = 1'b1;
          s_nxt.tmr = '0;
        end
      end
      HST_GAP: begin
        if (s_r.tmr == TMR_W'(ACQ_CYCLES)) begin
          s_nxt.st = HST_IDLE;
          s_nxt.tmr = '0;
        end
      end
      HST_DOWN: begin
        // select stands one cycle before power-down falls
        s_nxt.tmr = '0;
        if (s_r.pd_n && s_r.tmr == '0) begin
          s_nxt.pd_n = 1'b0;
        end else if (!down_req_i) begin
          s_nxt.pd_n = 1'b1;
          s_nxt.st = HST_WAKE;
        end
      end
      HST_WAKE: begin
        if (s_r.tmr == wake_last) begin
          s_nxt.st = HST_IDLE;
          s_nxt.select_n = 1'b0;
          s_nxt.tmr = '0;
        end
      end
    endcase
    s_nxt.idle = (s_nxt.st == HST_IDLE);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= HOST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign link.conversion_trigger_n = s_r.trig_n;
  assign link.select_n = s_r.select_n;
  assign link.read_n = s_r.read_n;
  assign link.power_down_n = s_r.pd_n;
  assign result_o = s_r.result;
  assign result_valid_o = s_r.result_valid;
  assign idle_o = s_r.idle;
endmodule

//--- verification/acs_link_props.sv
`timescale 1ns/1ps
// ==========================================================
// link checks
module acs_link_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // link signals
  input wire logic conversion_trigger_n,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic power_down_n,
  input wire logic busy_n,
  input wire logic data_oe_n,
  input wire logic [acs_pkg::RES_W-1:0] data
);
  import acs_pkg::*;
  logic [7:0] lo_cnt_r;
  logic [7:0] hi_cnt_r;
  logic [7:0] wake_cnt_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // busy low, busy high and wake-up cycle counters
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lo_cnt_r <= 8'h00;
      hi_cnt_r <= 8'h00;
      wake_cnt_r <= 8'hff;
    end else begin
      lo_cnt_r <= busy_n ? 8'h00 : lo_cnt_r + 8'h01;
      hi_cnt_r <= !busy_n ? 8'h00 : ((hi_cnt_r == 8'hff) ? hi_cnt_r : hi_cnt_r + 8'h01);
      wake_cnt_r <= !power_down_n ? 8'h00 :
        ((wake_cnt_r == 8'hff) ? wake_cnt_r : wake_cnt_r + 8'h01);
    end
  end

  // ==========================================================
  // assertions
  busy_start_a: assert property ($fell(conversion_trigger_n) && !select_n && busy_n &&
    hi_cnt_r > 8'(ACQ_CYCLES + 1) && wake_cnt_r == 8'hff |=> !busy_n)
    else $error("trigger with select low did not start a conversion");
  busy_len_a: assert property ($rose(busy_n) && power_down_n |->
    lo_cnt_r == 8'(CONV_CYCLES)) else $error("busy low length wrong");
  busy_max_a: assert property (!busy_n |-> lo_cnt_r < 8'(CONV_MAX_CYCLES))
    else $error("conversion too long");
  trig_cause_a: assert property ($fell(busy_n) |->
    !$past(conversion_trigger_n) && !$past(select_n)) else $error("busy without trigger");
  acq_gap_a: assert property ($fell(busy_n) |-> hi_cnt_r >= 8'(ACQ_CYCLES))
    else $error("conversion restarted too early");
  wake_gap_a: assert property ($fell(busy_n) |-> wake_cnt_r >= 8'(NAP_WAKE_CYCLES))
    else $error("conversion during wake-up");
  down_quiet_a: assert property (!power_down_n && !$past(power_down_n) |-> busy_n)
    else $error("busy during shutdown");
  oe_follow_a: assert property (data_oe_n == $past(select_n | read_n))
    else $error("data enable not following read");
  data_hold_a: assert property (!$rose(busy_n) |-> $stable(data))
    else $error("data changed outside conversion end");
  read_sel_a: assert property (!read_n |-> !select_n)
    else $error("read without select");

  cover property ($rose(busy_n));
  cover property ($fell(power_down_n) && !select_n);
  cover property ($fell(power_down_n) && select_n);
  cover property (!data_oe_n);
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import acs_pkg::*;
  localparam int SLP = 200;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic conv_req_i = 1'b0;
  logic down_req_i = 1'b0;
  logic sleep_mode_i = 1'b0;
  logic [RES_W-1:0] sample_i = '0;
  logic sample_valid_i = 1'b0;
  logic sample_ready_o;
  logic ready_o;
  logic nap_o;
  logic sleep_o;
  logic [RES_W-1:0] result_o;
  logic result_valid_o;
  logic idle_o;
  int error_cnt = 0;
  int total_checks = 0;
  logic [RES_W-1:0] exp_q[$];
  logic [RES_W-1:0] codes [4] = '{CODE_ZERO, CODE_MINUS_ONE, CODE_POS_FULL, CODE_POS_NEAR};

  always #4 clk_sys_i = ~clk_sys_i;

  // ==========================================================
  // both ends and checker
  acs_link_if u_acs_link_if ();
  acs_device #(.FIFO_DEPTH(FIFO_DEPTH), .SLEEP_WAKE_CYC(SLP)) u_acs_device (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_acs_link_if),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .ready_o(ready_o), .nap_o(nap_o), .sleep_o(sleep_o));
  acs_host #(.SLEEP_WAKE_CYC(SLP)) u_acs_host (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_acs_link_if),
    .conv_req_i(conv_req_i), .down_req_i(down_req_i), .sleep_mode_i(sleep_mode_i),
    .result_o(result_o), .result_valid_o(result_valid_o), .idle_o(idle_o));
  acs_link_props u_acs_link_props (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .conversion_trigger_n(u_acs_link_if.conversion_trigger_n),
    .select_n(u_acs_link_if.select_n), .read_n(u_acs_link_if.read_n),
    .power_down_n(u_acs_link_if.power_down_n), .busy_n(u_acs_link_if.busy_n),
    .data_oe_n(u_acs_link_if.data_oe_n), .data(u_acs_link_if.data));

  // ==========================================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task test_done;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task push(input logic [RES_W-1:0] c);
    sample_i = c;
    sample_valid_i = 1'b1;
    tick(1);
    sample_valid_i = 1'b0;
    tick(1);
  endtask

  task wait_idle;
    int n;
    n = 0;
    while (idle_o !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
  endtask

  task convert(input logic [RES_W-1:0] exp);
    int n;
    wait_idle();
    check(u_acs_link_if.data_oe_n, 1'b1);
    conv_req_i = 1'b1;
    tick(1);
    conv_req_i = 1'b0;
    n = 0;
    while (result_valid_o !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    check(u_acs_link_if.data_oe_n, 1'b0);
    check(n <= THRU_CYCLES, 1'b1);
    check(result_o, exp);
  endtask

  task shut(input logic slp, input int wake);
    int n;
    wait_idle();
    down_req_i = 1'b1;
    sleep_mode_i = slp;
    conv_req_i = 1'b1;
    tick(6);
    check(nap_o, !slp);
    check(sleep_o, slp);
    check(u_acs_link_if.select_n, slp);
    tick(20);
    check(u_acs_link_if.busy_n, 1'b1);
    check(ready_o, 1'b0);
    down_req_i = 1'b0;
    conv_req_i = 1'b0;
    n = 0;
    while (ready_o !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    check(n >= wake && n <= wake + 4, 1'b1);
    $display("shutdown test done, sleep=%0d", slp);
  endtask

  // ==========================================================
  // tests
  initial begin
    tick(10);
    reset_i = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      exp_q.push_back((i < 4) ? codes[i] : RES_W'(i * 14'h0531));
      check(sample_ready_o, 1'b1);
      push(exp_q[i]);
    end
    tick(2);
    check(sample_ready_o, 1'b0);
    sample_i = 14'h2aaa;
    sample_valid_i = 1'b1;
    tick(3);
    sample_valid_i = 1'b0;
    $display("fifo fill test done");
    for (int i = 0; i < FIFO_DEPTH; i++) convert(exp_q[i]);
    check(sample_ready_o, 1'b1);
    convert(exp_q[FIFO_DEPTH-1]);
    $display("conversion test done");
    shut(1'b0, NAP_WAKE_CYCLES);
    convert(exp_q[FIFO_DEPTH-1]);
    shut(1'b1, SLP);
    convert(exp_q[FIFO_DEPTH-1]);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    test_done();
  end
endmodule
